// ===== amp_mode_mute_fault_control.sv
// Control and status logic of a class-D amplifier with optional headphone path
//
// Operation
// - Power-down low sleeps whole device
// - Silence low turns on low-side transistors
// - Silence released restores normal output drive
// - Select low: class-D active, headphone sleeps
// - Select high: headphone active, class-D sleeps
// - Select falling returns to class-D operation
// - Two fault outputs encode four states
// - Headphone reports thermal and undervoltage only, same codes
// - Fault outputs open-drain, outside pull-up
// - Fault code held until power-down/silence toggled
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps

module amp_mode_mute_fault_control
(
  input  wire logic                      mclk,
  input  wire logic                      rst,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Control pins, asynchronous
  input  wire logic                      power_down_n,
  input  wire logic                      silence_n,
  input  wire logic                      amp_select,
  // Analog detectors, asynchronous
  input  wire amp_ctrl_pkg::detect_t     detect,
  // Stage controls
  output amp_ctrl_pkg::stage_ctl_t       stage_ctl,
  // Open-drain fault pins
  input  wire logic                      fault_code_bit0_in,
  input  wire logic                      fault_code_bit1_in,
  output logic                           fault_code_bit0_out,
  output logic                           fault_code_bit1_out,
  output logic                           fault_code_bit0_oe,
  output logic                           fault_code_bit1_oe,
  output logic                           irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [6:0] sync1_r;
  logic [6:0] sync2_r;
  logic [6:0] sync_nxt;

  always_comb
  begin
    sync_nxt = {power_down_n, silence_n, amp_select, detect};
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync1_r <= 7'h60;
      sync2_r <= 7'h60;
    end
    else
    begin
      sync1_r <= sync_nxt;
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and effective controls

  logic [3:0]              ctrl_r;
  logic [3:0]              ctrl_nxt;
  logic [3:0]              ev_st_r;
  logic [3:0]              ev_st_nxt;
  logic [3:0]              ev_mk_r;
  logic [3:0]              ev_mk_nxt;
  logic                    pd_n;
  logic                    sil_n;
  logic                    sel;
  amp_ctrl_pkg::detect_t   det;

  always_comb
  begin
    det   = amp_ctrl_pkg::detect_t'(sync2_r[3:0]);
    pd_n  = sync2_r[6];
    sil_n = sync2_r[5];
    sel   = sync2_r[4];
    if (ctrl_r[amp_ctrl_pkg::CTRL_SW_OVR_POS])
    begin
      pd_n  = ~ctrl_r[amp_ctrl_pkg::CTRL_SW_PD_POS];
      sil_n = ~ctrl_r[amp_ctrl_pkg::CTRL_SW_SIL_POS];
      sel   = ctrl_r[amp_ctrl_pkg::CTRL_SW_SEL_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine

  amp_ctrl_pkg::amp_state_t state_r;
  amp_ctrl_pkg::amp_state_t state_nxt;
  logic                     pd_n_d_r;
  logic                     sil_n_d_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      amp_ctrl_pkg::ST_SLEEP:
        if (pd_n)
          state_nxt = sel ? amp_ctrl_pkg::ST_HEADPHONE : amp_ctrl_pkg::ST_CLASSD;
      amp_ctrl_pkg::ST_CLASSD:
        if (!pd_n)
          state_nxt = amp_ctrl_pkg::ST_SLEEP;
        else if (sel)
          state_nxt = amp_ctrl_pkg::ST_HEADPHONE;
      amp_ctrl_pkg::ST_HEADPHONE:
        if (!pd_n)
          state_nxt = amp_ctrl_pkg::ST_SLEEP;
        else if (!sel)
          state_nxt = amp_ctrl_pkg::ST_CLASSD;
      default:
        state_nxt = amp_ctrl_pkg::ST_SLEEP;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r   <= amp_ctrl_pkg::ST_SLEEP;
      pd_n_d_r  <= 1'b1;
      sil_n_d_r <= 1'b1;
    end
    else
    begin
      state_r   <= state_nxt;
      pd_n_d_r  <= pd_n;
      sil_n_d_r <= sil_n;
    end
  end

  always_comb
  begin
    stage_ctl.sleep_all         = (state_r == amp_ctrl_pkg::ST_SLEEP);
    stage_ctl.classd_on         = (state_r == amp_ctrl_pkg::ST_CLASSD);
    stage_ctl.headphone_path_on = (state_r == amp_ctrl_pkg::ST_HEADPHONE);
    stage_ctl.low_side_on       = !stage_ctl.sleep_all && !sil_n;
    stage_ctl.drive_en          = !stage_ctl.sleep_all && sil_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault latch

  amp_ctrl_pkg::fault_kind_t flt_r;
  amp_ctrl_pkg::fault_kind_t flt_nxt;
  logic                      clr_toggle;
  logic                      thermal_now;

  always_comb
  begin
    clr_toggle  = (pd_n != pd_n_d_r) || (sil_n != sil_n_d_r);
    thermal_now = (stage_ctl.classd_on && det.thermal_cd)
               || (stage_ctl.headphone_path_on && det.thermal_hp);
    flt_nxt = clr_toggle ? amp_ctrl_pkg::FLT_NONE : flt_r;
    if (flt_r == amp_ctrl_pkg::FLT_NONE || clr_toggle)
    begin
      if (thermal_now)
        flt_nxt = amp_ctrl_pkg::FLT_THERMAL;
      else if (stage_ctl.classd_on && det.overcur)
        flt_nxt = amp_ctrl_pkg::FLT_OVERCUR;
      else if (!stage_ctl.sleep_all && det.underv)
        flt_nxt = amp_ctrl_pkg::FLT_UNDERV;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      flt_r <= amp_ctrl_pkg::FLT_NONE;
    else
      flt_r <= flt_nxt;
  end

  function automatic logic [1:0] fault_code(input amp_ctrl_pkg::fault_kind_t k);
    case (k)
      amp_ctrl_pkg::FLT_OVERCUR: fault_code = amp_ctrl_pkg::CODE_OVERCUR;
      amp_ctrl_pkg::FLT_THERMAL: fault_code = amp_ctrl_pkg::CODE_THERMAL;
      amp_ctrl_pkg::FLT_UNDERV:  fault_code = amp_ctrl_pkg::CODE_UNDERV;
      default:                   fault_code = amp_ctrl_pkg::CODE_NORMAL;
    endcase
  endfunction : fault_code

  logic [1:0] code;

  always_comb
  begin
    code                = fault_code(flt_r);
    fault_code_bit0_out = 1'b0;
    fault_code_bit1_out = 1'b0;
    fault_code_bit0_oe  = ~code[0];
    fault_code_bit1_oe  = ~code[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags and interrupt

  logic [3:0] ev_set;

  always_comb
  begin
    ev_set = 4'h0;
    ev_set[amp_ctrl_pkg::EV_OVERCUR_POS] = (flt_nxt == amp_ctrl_pkg::FLT_OVERCUR)
                                         && (flt_r != amp_ctrl_pkg::FLT_OVERCUR);
    ev_set[amp_ctrl_pkg::EV_THERMAL_POS] = (flt_nxt == amp_ctrl_pkg::FLT_THERMAL)
                                         && (flt_r != amp_ctrl_pkg::FLT_THERMAL);
    ev_set[amp_ctrl_pkg::EV_UNDERV_POS]  = (flt_nxt == amp_ctrl_pkg::FLT_UNDERV)
                                         && (flt_r != amp_ctrl_pkg::FLT_UNDERV);
    ev_set[amp_ctrl_pkg::EV_MODE_POS]    = (state_nxt != state_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  logic        wr_acc;
  logic        rd_hit;
  logic [31:0] rdata_nxt;
  logic        err_nxt;

  always_comb
  begin
    wr_acc    = psel && penable && pwrite;
    ctrl_nxt  = ctrl_r;
    ev_mk_nxt = ev_mk_r;
    ev_st_nxt = ev_st_r;
    rdata_nxt = 32'h0000_0000;
    rd_hit    = 1'b1;
    if (paddr == amp_ctrl_pkg::CTRL_OFS)
    begin
      rdata_nxt = {28'h0, ctrl_r};
      if (wr_acc)
        ctrl_nxt = pwdata[3:0];
    end
    else if (paddr == amp_ctrl_pkg::STATE_OFS)
      rdata_nxt = {24'h0, 2'(state_r), 2'(flt_r), code, pd_n, sil_n};
    else if (paddr == amp_ctrl_pkg::IRQ_ST_OFS)
    begin
      rdata_nxt = {28'h0, ev_st_r};
      if (wr_acc)
        ev_st_nxt = ev_st_r & ~pwdata[3:0];
    end
    else if (paddr == amp_ctrl_pkg::IRQ_MK_OFS)
    begin
      rdata_nxt = {28'h0, ev_mk_r};
      if (wr_acc)
        ev_mk_nxt = pwdata[3:0];
    end
    else
      rd_hit = 1'b0;
    ev_st_nxt = ev_st_nxt | ev_set;
    err_nxt   = psel && penable && !rd_hit;
    pready    = psel && penable;
    pslverr   = err_nxt;
    prdata    = rdata_nxt;
    irq       = |(ev_st_r & ev_mk_r);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl_r  <= amp_ctrl_pkg::CTRL_RST;
      ev_st_r <= 4'h0;
      ev_mk_r <= amp_ctrl_pkg::MASK_RST;
    end
    else
    begin
      ctrl_r  <= ctrl_nxt;
      ev_st_r <= ev_st_nxt;
      ev_mk_r <= ev_mk_nxt;
    end
  end

endmodule : amp_mode_mute_fault_control

// ===== amp_ctrl_pkg.sv
// Package with constants and types for the amplifier mode, mute and fault control
package amp_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATE_OFS  = 8'h04;
  localparam logic [7:0] IRQ_ST_OFS = 8'h08;
  localparam logic [7:0] IRQ_MK_OFS = 8'h0C;

  // Control register fields
  localparam int CTRL_SW_OVR_POS = 0;
  localparam int CTRL_SW_PD_POS  = 1;
  localparam int CTRL_SW_SIL_POS = 2;
  localparam int CTRL_SW_SEL_POS = 3;

  // Event bit positions, shared by status and mask
  localparam int EV_OVERCUR_POS = 0;
  localparam int EV_THERMAL_POS = 1;
  localparam int EV_UNDERV_POS  = 2;
  localparam int EV_MODE_POS    = 3;
  localparam int EV_W           = 4;

  // Reset values
  localparam logic [3:0]      CTRL_RST = 4'h0;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

  // Fault codes, bit1/bit0 as driven on the pins (1 = released)
  localparam logic [1:0] CODE_NORMAL  = 2'h3;
  localparam logic [1:0] CODE_OVERCUR = 2'h1;
  localparam logic [1:0] CODE_UNDERV  = 2'h2;
  localparam logic [1:0] CODE_THERMAL = 2'h0;

  typedef enum logic [1:0] {FLT_NONE, FLT_OVERCUR, FLT_THERMAL, FLT_UNDERV} fault_kind_t;

  typedef enum {ST_SLEEP, ST_CLASSD, ST_HEADPHONE} amp_state_t;

  // Analog detector inputs
  typedef struct packed {
    logic overcur;
    logic thermal_cd;
    logic thermal_hp;
    logic underv;
  } detect_t;

  // Controls to the analog power stages
  typedef struct packed {
    logic sleep_all;
    logic classd_on;
    logic headphone_path_on;
    logic low_side_on;
    logic drive_en;
  } stage_ctl_t;

endpackage : amp_ctrl_pkg

// ===== amp_ctrl_properties.sv
// Concurrent checks on the amplifier control ports
`timescale 1ns/10ps
module amp_ctrl_properties
(
  input wire logic                     mclk,
  input wire logic                     rst,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic [7:0]               paddr,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     power_down_n,
  input wire logic                     silence_n,
  input wire logic                     amp_select,
  input wire amp_ctrl_pkg::stage_ctl_t stage_ctl,
  input wire logic                     fault_code_bit0_out,
  input wire logic                     fault_code_bit1_out,
  input wire logic                     fault_code_bit0_oe,
  input wire logic                     fault_code_bit1_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_apb_ready: assert property (psel && penable |-> pready) else $error("ready missing");
  a_apb_unmapped: assert property (psel && penable && paddr > 8'h0C |-> pslverr)
    else $error("unmapped access not refused");
  a_drain_low: assert property (!fault_code_bit0_out && !fault_code_bit1_out)
    else $error("fault line driven high");
  a_sleep_all: assert property (!power_down_n [*4] |-> stage_ctl.sleep_all)
    else $error("no sleep in power-down");
  a_silence_low: assert property ((power_down_n && !silence_n) [*4] |->
    stage_ctl.low_side_on) else $error("low side off while silenced");
  a_drive_back: assert property ((power_down_n && silence_n && !amp_select) [*5] |->
    stage_ctl.drive_en && !stage_ctl.low_side_on) else $error("drive not restored");
  a_classd_pick: assert property ((power_down_n && !amp_select) [*5] |->
    stage_ctl.classd_on && !stage_ctl.headphone_path_on) else $error("class-D not active");
  a_hp_pick: assert property ((power_down_n && amp_select) [*5] |->
    stage_ctl.headphone_path_on && !stage_ctl.classd_on) else $error("headphone not active");
  a_fault_hold: assert property (($stable(power_down_n) && $stable(silence_n)) [*6] |->
    !$fell(fault_code_bit0_oe) && !$fell(fault_code_bit1_oe)) else $error("fault dropped");
endmodule : amp_ctrl_properties

bind amp_mode_mute_fault_control amp_ctrl_properties i_props
(
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .power_down_n(power_down_n), .silence_n(silence_n),
  .amp_select(amp_select), .stage_ctl(stage_ctl), .fault_code_bit0_out(fault_code_bit0_out),
  .fault_code_bit1_out(fault_code_bit1_out), .fault_code_bit0_oe(fault_code_bit0_oe),
  .fault_code_bit1_oe(fault_code_bit1_oe)
);

// ===== fault_pullup_model.sv
// Host side pull-ups on the open-drain fault lines
`timescale 1ns/10ps
module fault_pullup_model
(
  input  wire logic out0,
  input  wire logic out1,
  input  wire logic oe0,
  input  wire logic oe1,
  output logic      pin0,
  output logic      pin1
);
  // Released line is pulled up
  assign pin0 = oe0 ? out0 : 1'b1;
  assign pin1 = oe1 ? out1 : 1'b1;
endmodule : fault_pullup_model

// ===== amp_mode_mute_fault_control_tb.sv
// Self-checking testbench for the amplifier control block
`timescale 1ns/10ps
module amp_mode_mute_fault_control_tb;
  logic                     mclk = 1'b0;
  logic                     rst = 1'b1;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic [7:0]               paddr = 8'h00;
  logic [31:0]              pwdata = 32'h0;
  logic                     pd_n = 1'b1;
  logic                     sil_n = 1'b1;
  logic                     sel = 1'b0;
  amp_ctrl_pkg::detect_t    det = 4'h0;
  amp_ctrl_pkg::stage_ctl_t stc;
  logic [31:0]              prdata;
  logic [31:0]              rd;
  logic                     pready, pslverr, irq, er, o0, o1, e0, e1, pin0, pin1;
  int                       err_total = 0;
  int                       n_compared = 0;

  always #2 mclk = ~mclk;

  amp_mode_mute_fault_control i_dut
  (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down_n(pd_n), .silence_n(sil_n), .amp_select(sel), .detect(det), .stage_ctl(stc),
    .fault_code_bit0_in(pin0), .fault_code_bit1_in(pin1), .fault_code_bit0_out(o0),
    .fault_code_bit1_out(o1), .fault_code_bit0_oe(e0), .fault_code_bit1_oe(e1), .irq(irq)
  );

  fault_pullup_model i_host
  (
    .out0(o0), .out1(o1), .oe0(e0), .oe1(e1), .pin0(pin0), .pin1(pin1)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
    begin
      k++;
      if (k > 20)
      begin
        err_total++;
        final_report;
      end
      @(posedge mclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pins(input logic p, input logic s, input logic m, input logic [3:0] d);
    @(posedge mclk);
    pd_n <= p;
    sil_n <= s;
    sel <= m;
    det <= d;
    repeat (6) @(posedge mclk);
  endtask : pins

  task automatic code(input logic [1:0] exp);
    chk("fault pins", {30'h0, exp}, {30'h0, pin1, pin0});
  endtask : code

  task automatic mode(input logic [1:0] exp);
    apb(1'b0, amp_ctrl_pkg::STATE_OFS, 32'h0);
    chk("mode", {30'h0, exp}, {30'h0, rd[7:6]});
  endtask : mode

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(1'b0, amp_ctrl_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, amp_ctrl_pkg::IRQ_MK_OFS, 32'h0);
    chk("mask", 32'h0, rd);
    apb(1'b0, amp_ctrl_pkg::IRQ_ST_OFS, 32'h0);
    chk("status", 32'h8, rd);
    apb(1'b1, amp_ctrl_pkg::IRQ_ST_OFS, 32'hF);
    code(2'h3);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk("wr err", 32'h1, {31'h0, er});
    apb(1'b0, 8'h10, 32'h0);
    chk("rd err", 32'h1, {31'h0, er});
    chk("rd data", 32'h0, rd);
  endtask : t_regs

  task automatic t_mode;
    apb(1'b1, amp_ctrl_pkg::IRQ_MK_OFS, 32'h8);
    pins(1'b1, 1'b1, 1'b1, 4'h0);
    mode(2'h2);
    chk("hp on", 32'h1, {31'h0, stc.headphone_path_on});
    chk("irq set", 32'h1, {31'h0, irq});
    apb(1'b1, amp_ctrl_pkg::IRQ_ST_OFS, 32'h8);
    @(posedge mclk);
    chk("irq clr", 32'h0, {31'h0, irq});
    pins(1'b1, 1'b1, 1'b0, 4'h0);
    mode(2'h1);
    chk("classd on", 32'h1, {31'h0, stc.classd_on});
    pins(1'b0, 1'b1, 1'b1, 4'h0);
    mode(2'h0);
    chk("sleep", 32'h1, {31'h0, stc.sleep_all});
    pins(1'b1, 1'b0, 1'b0, 4'h0);
    chk("low side", 32'h1, {31'h0, stc.low_side_on});
    pins(1'b1, 1'b1, 1'b0, 4'h0);
    chk("drive", 32'h1, {31'h0, stc.drive_en});
  endtask : t_mode

  task automatic t_fault;
    apb(1'b1, amp_ctrl_pkg::IRQ_MK_OFS, 32'h7);
    apb(1'b1, amp_ctrl_pkg::IRQ_ST_OFS, 32'hF);
    pins(1'b1, 1'b1, 1'b0, 4'h8);
    code(2'h1);
    apb(1'b0, amp_ctrl_pkg::IRQ_ST_OFS, 32'h0);
    chk("oc event", 32'h1, rd & 32'h7);
    chk("irq fault", 32'h1, {31'h0, irq});
    pins(1'b1, 1'b1, 1'b0, 4'hC);
    code(2'h1);
    pins(1'b1, 1'b0, 1'b0, 4'hC);
    code(2'h0);
    pins(1'b1, 1'b1, 1'b0, 4'h0);
    code(2'h3);
    pins(1'b1, 1'b1, 1'b1, 4'h0);
    pins(1'b1, 1'b1, 1'b1, 4'h8);
    code(2'h3);
    pins(1'b1, 1'b1, 1'b1, 4'h2);
    code(2'h0);
    pins(1'b1, 1'b0, 1'b0, 4'h1);
    code(2'h2);
    pins(1'b0, 1'b1, 1'b0, 4'h0);
    code(2'h3);
    apb(1'b1, amp_ctrl_pkg::IRQ_ST_OFS, 32'hF);
    @(posedge mclk);
    chk("irq end", 32'h0, {31'h0, irq});
  endtask : t_fault

  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_mode;
    t_fault;
    final_report;
  end
endmodule : amp_mode_mute_fault_control_tb
